/* hw/crc16_byte.sv */
// One byte step of the 16-bit frame check, fully combinational
`default_nettype none
module crc16_byte (
  input wire logic [15:0] i_crc,
  input wire logic [7:0] i_data,
  output logic [15:0] o_crc
);
  logic [15:0] stage [0:8];

  // ==========================================================
  // Byte enters the low bits, then eight shift steps
  assign stage[0] = i_crc ^ {8'h00, i_data};
  genvar k;
  generate
    for (k = 0; k < 8; k = k + 1) begin : g_bit
      // Right shift with zero fill, fold in polynomial on a one
      assign stage[k + 1] = stage[k][0] ?
        ((stage[k] >> 1) ^ rtu_pkg::CRC_POLY) : (stage[k] >> 1);
    end
  endgenerate
  assign o_crc = stage[8];
endmodule
`default_nettype wire

/* hw/rtu_pkg.sv */
// Constants, field positions and state type for the RTU word-access slave
`default_nettype none
package rtu_pkg;
  // ==========================================================
  // Check calculation
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;
  // ==========================================================
  // Command codes and station addresses
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h06;
  localparam logic [7:0] STATION_BCAST = 8'h00;
  localparam logic [7:0] STATION_MAX = 8'hF7;
  localparam int MAX_WORDS_DEF = 12;
  // ==========================================================
  // Request layout: every supported request is eight bytes
  localparam logic [3:0] FRAME_LEN = 4'h8;
  localparam logic [3:0] FRAME_OVER = 4'h9;
  localparam int FLD_STATION = 0;
  localparam int FLD_CMD = 1;
  localparam int FLD_REG_HI = 2;
  localparam int FLD_REG_LO = 3;
  localparam int FLD_VAL_HI = 4;
  localparam int FLD_VAL_LO = 5;
  localparam logic [2:0] HDR_LAST_READ = 3'h2;
  localparam logic [2:0] HDR_LAST_WRITE = 3'h5;
  // ==========================================================
  // Word address mapping
  localparam int VOLATILE_BIT = 15;
  localparam int GROUP_MSB = 11;
  localparam int GROUP_LSB = 8;
  // ==========================================================
  // Line timing, idle gaps in tenths of a character time
  localparam int CLK_HZ = 125_000_000;
  localparam int BAUD_DEF = 9600;
  localparam int CHAR_BITS = 11;
  localparam int CHAR_CYCLES_DEF = (CLK_HZ / BAUD_DEF) * CHAR_BITS;
  localparam int GAP_END_TENTHS = 15;
  localparam int GAP_FRAME_TENTHS = 35;
  localparam int TENTHS = 10;
  // ==========================================================
  // Responder states, Gray along the read path
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HEAD = 3'b001,
    ST_FETCH = 3'b011,
    ST_WHI = 3'b010,
    ST_WLO = 3'b110,
    ST_CRCL = 3'b111,
    ST_CRCH = 3'b101
  } resp_state_t;
endpackage
`default_nettype wire

/* hw/rtu_slave_word_access.sv */
// Slave command handler: word read, single word write, frame check
`default_nettype none
module rtu_slave_word_access #(
  parameter int CHAR_CYCLES = rtu_pkg::CHAR_CYCLES_DEF,
  parameter int MAX_WORDS = rtu_pkg::MAX_WORDS_DEF
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [7:0] i_station_addr,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  input wire logic i_tx_ready,
  output logic o_par_rd_req,
  output logic o_par_wr_req,
  output logic [3:0] o_par_group,
  output logic [7:0] o_par_index,
  output logic o_par_volatile,
  output logic [15:0] o_par_wr_data,
  input wire logic i_par_rd_valid,
  input wire logic [15:0] i_par_rd_data,
  output logic o_frame_error,
  output logic o_busy
);
  // Least idle times, rounded up to whole cycles
  localparam int T15 = (CHAR_CYCLES * rtu_pkg::GAP_END_TENTHS
    + rtu_pkg::TENTHS - 1) / rtu_pkg::TENTHS;
  localparam int T35 = (CHAR_CYCLES * rtu_pkg::GAP_FRAME_TENTHS
    + rtu_pkg::TENTHS - 1) / rtu_pkg::TENTHS;
  localparam logic [31:0] T15_C = 32'(T15);
  localparam logic [31:0] T35_C = 32'(T35);
  localparam logic [3:0] MAX_W = 4'(MAX_WORDS);

  // ==========================================================
  // Receiver: gap timing and frame capture
  localparam int FRAME_BYTES = int'(rtu_pkg::FRAME_LEN);
  logic [31:0] gap_r, gap_nxt;
  logic in_frame_r, in_frame_nxt, armed_r, armed_nxt;
  logic frame_rdy_r, frame_rdy_nxt;
  logic [3:0] cnt_r, cnt_nxt, widx;
  logic [7:0] fr_r [0:FRAME_BYTES-1];
  logic [15:0] rx_crc_r, rx_crc_nxt, rx_crc_in, rx_crc_out;
  logic start, store, discard;
  logic ferr_r, ferr_nxt;

  // Idle gap decides where frames begin and end; the counter
  // saturates so a long quiet line never wraps into a false start
  always_comb begin
    gap_nxt = gap_r;
    in_frame_nxt = in_frame_r;
    armed_nxt = armed_r;
    cnt_nxt = cnt_r;
    frame_rdy_nxt = 1'b0;
    start = 1'b0;
    store = 1'b0;
    discard = 1'b0;
    if (i_rx_valid) begin
      gap_nxt = '0;
      armed_nxt = 1'b0;
      if (in_frame_r) begin
        store = (cnt_r < rtu_pkg::FRAME_LEN);
        if (cnt_r != rtu_pkg::FRAME_OVER) begin
          cnt_nxt = cnt_r + 4'h1;
        end
      end else if (armed_r) begin
        start = 1'b1;
        store = 1'b1;
        in_frame_nxt = 1'b1;
        cnt_nxt = 4'h1;
      end
    end else begin
      if (gap_r != T35_C) begin
        gap_nxt = gap_r + 32'h1;
      end
      // Bytes seen on a line that was not quiet long enough are noise
      if (!in_frame_r && gap_r == T35_C - 32'h1) begin
        armed_nxt = 1'b1;
      end
      // Short or overlong frame: drop it, next byte is an address
      if (in_frame_r && cnt_r != rtu_pkg::FRAME_LEN &&
          gap_r == T15_C - 32'h1) begin
        discard = 1'b1;
        in_frame_nxt = 1'b0;
        armed_nxt = 1'b1;
      end
      // A full request counts only once the end gap has passed
      if (in_frame_r && cnt_r == rtu_pkg::FRAME_LEN &&
          gap_r == T35_C - 32'h1) begin
        frame_rdy_nxt = 1'b1;
        in_frame_nxt = 1'b0;
        armed_nxt = 1'b1;
      end
    end
  end

  // ==========================================================
  // Receive check: preset on the address byte, data bits only
  assign rx_crc_in = start ? rtu_pkg::CRC_PRESET : rx_crc_r;
  assign rx_crc_nxt = store ? rx_crc_out : rx_crc_r;
  assign widx = start ? 4'h0 : cnt_r;

  crc16_byte u_rx_crc (
    .i_crc(rx_crc_in),
    .i_data(i_rx_data),
    .o_crc(rx_crc_out)
  );

  // Receiver registers
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      gap_r <= '0;
      in_frame_r <= 1'b0;
      armed_r <= 1'b0;
      frame_rdy_r <= 1'b0;
      cnt_r <= '0;
      rx_crc_r <= rtu_pkg::CRC_PRESET;
    end else begin
      gap_r <= gap_nxt;
      in_frame_r <= in_frame_nxt;
      armed_r <= armed_nxt;
      frame_rdy_r <= frame_rdy_nxt;
      cnt_r <= cnt_nxt;
      rx_crc_r <= rx_crc_nxt;
    end
  end

  // One byte slot per request field; the check bytes land last
  genvar j;
  generate
    for (j = 0; j < FRAME_BYTES; j = j + 1) begin : g_field
      logic [7:0] slot_nxt;
      assign slot_nxt = (store && widx == 4'(j)) ? i_rx_data : fr_r[j];
      always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
          fr_r[j] <= 8'h00;
        end else begin
          fr_r[j] <= slot_nxt;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Responder: decode, parameter access and reply framing
  rtu_pkg::resp_state_t state_r, state_nxt;
  logic [2:0] hidx_r, hidx_nxt;
  logic [3:0] left_r, left_nxt;
  logic [15:0] wa_r, wa_nxt, word_r, word_nxt, wdata_r, wdata_nxt;
  logic [15:0] tx_crc_r, tx_crc_nxt, tx_crc_out;
  logic is_read_r, is_read_nxt, rd_req_r, rd_req_nxt;
  logic wr_req_r, wr_req_nxt, busy_r, busy_nxt;
  logic [15:0] req_addr, req_val;
  logic [7:0] tx_byte, hdr_byte;
  logic crc_ok, station_ok, own, bcast, count_ok;
  logic is_rd_cmd, is_wr_cmd, rd_go, wr_go, emit, tx_push, buf_ready;

  // Field decode of the captured request
  assign req_addr = {fr_r[rtu_pkg::FLD_REG_HI],
    fr_r[rtu_pkg::FLD_REG_LO]};
  assign req_val = {fr_r[rtu_pkg::FLD_VAL_HI],
    fr_r[rtu_pkg::FLD_VAL_LO]};
  assign crc_ok = (rx_crc_r == rtu_pkg::CRC_RESIDUE);
  // An own address of zero or above the range never matches
  assign station_ok = (i_station_addr != rtu_pkg::STATION_BCAST) &&
    (i_station_addr <= rtu_pkg::STATION_MAX);
  assign own = station_ok &&
    (fr_r[rtu_pkg::FLD_STATION] == i_station_addr);
  assign bcast = (fr_r[rtu_pkg::FLD_STATION] == rtu_pkg::STATION_BCAST);
  assign is_rd_cmd = (fr_r[rtu_pkg::FLD_CMD] == rtu_pkg::CMD_READ);
  assign is_wr_cmd = (fr_r[rtu_pkg::FLD_CMD] == rtu_pkg::CMD_WRITE);
  assign count_ok = (req_val != 16'h0000) &&
    (req_val <= {12'h000, MAX_W});
  // A read to everyone would collide on the line, so it is ignored
  assign rd_go = frame_rdy_r && crc_ok && own && is_rd_cmd && count_ok;
  assign wr_go = frame_rdy_r && crc_ok && (own || bcast) && is_wr_cmd;

  // Header bytes echo the request; only the read count is rebuilt.
  // Limitation: a new frame during a reply would change the echo.
  assign hdr_byte = (is_read_r && hidx_r == rtu_pkg::HDR_LAST_READ) ?
    {req_val[6:0], 1'b0} : fr_r[hidx_r];
  assign emit = (state_r == rtu_pkg::ST_HEAD) ||
    (state_r == rtu_pkg::ST_WHI) || (state_r == rtu_pkg::ST_WLO) ||
    (state_r == rtu_pkg::ST_CRCL) || (state_r == rtu_pkg::ST_CRCH);
  assign tx_push = emit && buf_ready;

  // Byte offered to the output buffer in each sending state
  always_comb begin
    tx_byte = 8'h00;
    unique case (state_r)
      rtu_pkg::ST_HEAD: tx_byte = hdr_byte;
      rtu_pkg::ST_WHI: tx_byte = word_r[15:8];
      rtu_pkg::ST_WLO: tx_byte = word_r[7:0];
      rtu_pkg::ST_CRCL: tx_byte = tx_crc_r[7:0];
      rtu_pkg::ST_CRCH: tx_byte = tx_crc_r[15:8];
      default: tx_byte = 8'h00;
    endcase
  end

  crc16_byte u_tx_crc (
    .i_crc(tx_crc_r),
    .i_data(tx_byte),
    .o_crc(tx_crc_out)
  );

  // Reply sequencing; each sending state waits for room in the buffer, ST_FETCH waits for the read word
  always_comb begin
    state_nxt = state_r;
    hidx_nxt = hidx_r;
    left_nxt = left_r;
    wa_nxt = wa_r;
    word_nxt = word_r;
    wdata_nxt = wdata_r;
    is_read_nxt = is_read_r;
    tx_crc_nxt = tx_crc_r;
    wr_req_nxt = 1'b0;
    unique case (state_r)
      rtu_pkg::ST_IDLE: begin
        if (rd_go || wr_go) begin
          wa_nxt = req_addr;
          hidx_nxt = 3'h0;
          left_nxt = req_val[3:0];
          is_read_nxt = rd_go;
          tx_crc_nxt = rtu_pkg::CRC_PRESET;
        end
        if (wr_go) begin
          wdata_nxt = req_val;
          wr_req_nxt = 1'b1;
        end
        if (rd_go || (wr_go && !bcast)) begin
          state_nxt = rtu_pkg::ST_HEAD;
        end
      end
      rtu_pkg::ST_HEAD: begin
        if (buf_ready) begin
          tx_crc_nxt = tx_crc_out;
          if (is_read_r && hidx_r == rtu_pkg::HDR_LAST_READ) begin
            state_nxt = rtu_pkg::ST_FETCH;
          end else if (!is_read_r && hidx_r == rtu_pkg::HDR_LAST_WRITE) begin
            state_nxt = rtu_pkg::ST_CRCL;
          end else begin
            hidx_nxt = hidx_r + 3'h1;
          end
        end
      end
      rtu_pkg::ST_FETCH: begin
        if (i_par_rd_valid) begin
          word_nxt = i_par_rd_data;
          state_nxt = rtu_pkg::ST_WHI;
        end
      end
      rtu_pkg::ST_WHI: begin
        if (buf_ready) begin
          tx_crc_nxt = tx_crc_out;
          state_nxt = rtu_pkg::ST_WLO;
        end
      end
      rtu_pkg::ST_WLO: begin
        if (buf_ready) begin
          tx_crc_nxt = tx_crc_out;
          left_nxt = left_r - 4'h1;
          wa_nxt = wa_r + 16'h0001;
          if (left_r == 4'h1) begin
            state_nxt = rtu_pkg::ST_CRCL;
          end else begin
            state_nxt = rtu_pkg::ST_FETCH;
          end
        end
      end
      rtu_pkg::ST_CRCL: begin
        if (buf_ready) begin
          state_nxt = rtu_pkg::ST_CRCH;
        end
      end
      rtu_pkg::ST_CRCH: begin
        if (buf_ready) begin
          state_nxt = rtu_pkg::ST_IDLE;
        end
      end
      default: state_nxt = rtu_pkg::ST_IDLE;
    endcase
    rd_req_nxt = (state_nxt == rtu_pkg::ST_FETCH);
    busy_nxt = (state_nxt != rtu_pkg::ST_IDLE);
  end

  // Damaged check or a line gone quiet mid-frame is flagged
  assign ferr_nxt = discard || (frame_rdy_r && !crc_ok);

  // Responder registers
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state_r <= rtu_pkg::ST_IDLE;
      hidx_r <= '0;
      left_r <= '0;
      wa_r <= '0;
      word_r <= '0;
      wdata_r <= '0;
      is_read_r <= 1'b0;
      tx_crc_r <= rtu_pkg::CRC_PRESET;
      rd_req_r <= 1'b0;
      wr_req_r <= 1'b0;
      busy_r <= 1'b0;
      ferr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      hidx_r <= hidx_nxt;
      left_r <= left_nxt;
      wa_r <= wa_nxt;
      word_r <= word_nxt;
      wdata_r <= wdata_nxt;
      is_read_r <= is_read_nxt;
      tx_crc_r <= tx_crc_nxt;
      rd_req_r <= rd_req_nxt;
      wr_req_r <= wr_req_nxt;
      busy_r <= busy_nxt;
      ferr_r <= ferr_nxt;
    end
  end

  // ==========================================================
  // Outputs, all taken from registers
  assign o_par_rd_req = rd_req_r;
  assign o_par_wr_req = wr_req_r;
  assign o_par_group = wa_r[rtu_pkg::GROUP_MSB:rtu_pkg::GROUP_LSB];
  assign o_par_index = wa_r[rtu_pkg::GROUP_LSB-1:0];
  assign o_par_volatile = wa_r[rtu_pkg::VOLATILE_BIT];
  assign o_par_wr_data = wdata_r;
  assign o_frame_error = ferr_r;
  assign o_busy = busy_r;

  // Two entries let the host stall without losing a reply byte
  skid_buffer2 #(
    .WIDTH(8)
  ) u_tx_buf (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_in_valid(emit),
    .i_in_data(tx_byte),
    .o_in_ready(buf_ready),
    .o_out_valid(o_tx_valid),
    .o_out_data(o_tx_data),
    .i_out_ready(i_tx_ready)
  );

  // ==========================================================
  // Checks on the receive, decode and reply paths
  sequence word_taken_s;
    state_r == rtu_pkg::ST_FETCH && i_par_rd_valid;
  endsequence
  sequence check_low_sent_s;
    state_r == rtu_pkg::ST_CRCL && tx_push;
  endsequence

  rd_hold_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    rd_req_r && !i_par_rd_valid |=> rd_req_r)
    else $error("read request dropped early");

  fetch_word_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    word_taken_s |=> state_r == rtu_pkg::ST_WHI &&
      word_r == $past(i_par_rd_data))
    else $error("fetched word not held");

  check_order_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    check_low_sent_s |=> state_r == rtu_pkg::ST_CRCH)
    else $error("check high byte not next");

  bcast_quiet_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    frame_rdy_r && state_r == rtu_pkg::ST_IDLE && bcast |=>
      state_r == rtu_pkg::ST_IDLE)
    else $error("reply to broadcast");

  bad_check_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    frame_rdy_r && state_r == rtu_pkg::ST_IDLE && !crc_ok |=>
      state_r == rtu_pkg::ST_IDLE && !wr_req_r)
    else $error("damaged frame acted on");

  count_limit_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    frame_rdy_r && state_r == rtu_pkg::ST_IDLE && is_rd_cmd &&
      !count_ok |=> state_r == rtu_pkg::ST_IDLE)
    else $error("bad word count executed");

  gap_drop_a: assert property (
    @(posedge i_clock) disable iff (i_reset)
    discard |=> !in_frame_r && ferr_r)
    else $error("partial frame not dropped");
endmodule
`default_nettype wire

/* hw/skid_buffer2.sv */
// Two-entry buffer with valid and ready on both sides
`default_nettype none
module skid_buffer2 #(
  parameter int WIDTH = 8
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  logic v0_r, v1_r, v0_nxt, v1_nxt;
  logic [WIDTH-1:0] d0_r, d1_r, d0_nxt, d1_nxt;
  logic push, pop;

  // Ready only from the tail flag, so no path from out to in
  assign o_in_ready = !v1_r;
  assign o_out_valid = v0_r;
  assign o_out_data = d0_r;
  assign push = i_in_valid && !v1_r;
  assign pop = v0_r && i_out_ready;

  // ==========================================================
  // Head entry drains first, tail slides forward on a pop
  always_comb begin
    v0_nxt = v0_r;
    v1_nxt = v1_r;
    d0_nxt = d0_r;
    d1_nxt = d1_r;
    if (pop) begin
      v0_nxt = v1_r;
      d0_nxt = d1_r;
      v1_nxt = 1'b0;
    end
    if (push) begin
      if (!v0_nxt) begin
        v0_nxt = 1'b1;
        d0_nxt = i_in_data;
      end else begin
        v1_nxt = 1'b1;
        d1_nxt = i_in_data;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      v0_r <= 1'b0;
      v1_r <= 1'b0;
      d0_r <= '0;
      d1_r <= '0;
    end else begin
      v0_r <= v0_nxt;
      v1_r <= v1_nxt;
      d0_r <= d0_nxt;
      d1_r <= d1_nxt;
    end
  end

  // Tail is never filled while the head is empty
  tail_order_a: assert property (@(posedge i_clock) disable iff (i_reset)
    v1_r |-> v0_r) else $error("tail valid without head");
endmodule
`default_nettype wire

/* tb/host_sink.sv */
// Host model that takes reply bytes and stalls one cycle in four
`default_nettype none
module host_sink (
  input wire logic i_clock,
  input wire logic i_valid,
  input wire logic [7:0] i_data,
  output logic o_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase_r = 2'h0;
  logic [7:0] got[$];
  // Stalls make the two-entry buffer hold bytes
  assign o_ready = (phase_r != 2'h3);
  // Ready moves on the falling edge, bytes are taken on the rising one
  always @(negedge i_clock) phase_r <= phase_r + 2'h1;
  always @(posedge i_clock) begin
    if (i_valid && o_ready) got.push_back(i_data);
  end
endmodule
`default_nettype wire

/* tb/rtu_slave_word_access_tb.sv */
// Self-checking bench for the word-access slave
`default_nettype none
module rtu_slave_word_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 1'b0, i_reset = 1'b1, rx_valid = 1'b0, rd_valid = 1'b0;
  logic tx_valid, tx_ready, rd_req, wr_req, vol, ferr, busy;
  logic [7:0] rx_data = 8'h00, tx_data, index;
  logic [3:0] group;
  logic [15:0] wr_data;
  logic [28:0] wr_seen = 29'h0;
  int n_errors = 0, samples_checked = 0, cycles = 0, n_rd = 0, n_ferr = 0;
  // =========================================
  // Clock, parameter store and hang guard
  initial forever #4 i_clock = ~i_clock;
  always @(negedge i_clock) begin
    rd_valid <= rd_req;
    cycles <= cycles + 1;
    if (wr_req) wr_seen <= {vol, group, index, wr_data};
    if (rd_req) n_rd <= n_rd + 1;
    if (ferr) n_ferr <= n_ferr + 1;
    if (cycles == 30000) begin
      n_errors++;
      give_verdict();
    end
  end
  rtu_slave_word_access #(.CHAR_CYCLES(20), .MAX_WORDS(12)) u_dut (
    .i_clock(i_clock), .i_reset(i_reset), .i_station_addr(8'h01),
    .i_rx_valid(rx_valid), .i_rx_data(rx_data), .o_tx_valid(tx_valid),
    .o_tx_data(tx_data), .i_tx_ready(tx_ready), .o_par_rd_req(rd_req),
    .o_par_wr_req(wr_req), .o_par_group(group), .o_par_index(index),
    .o_par_volatile(vol), .o_par_wr_data(wr_data),
    .i_par_rd_valid(rd_valid), .i_par_rd_data({4'hA, group, index}),
    .o_frame_error(ferr), .o_busy(busy));
  host_sink u_host (.i_clock(i_clock), .i_valid(tx_valid),
    .i_data(tx_data), .o_ready(tx_ready));
  // =========================================
  // Shared tasks
  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  task automatic compare(input string what, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  // A flipped check bit models a damaged frame
  task automatic send(input logic [7:0] b[$], input logic bad);
    logic [15:0] c;
    c = crc(b) ^ {15'h0, bad};
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    foreach (b[i]) begin
      @(negedge i_clock) rx_valid = 1'b1;
      rx_data = b[i];
      @(negedge i_clock) rx_valid = 1'b0;
    end
    repeat (200) @(negedge i_clock);
  endtask
  task automatic expect_reply(input logic [7:0] e[$]);
    logic [15:0] c;
    c = crc(e);
    if (e.size() > 0) e.push_back(c[7:0]);
    if (e.size() > 1) e.push_back(c[15:8]);
    compare("reply length", e.size(), u_host.got.size());
    foreach (e[i]) if (i < u_host.got.size())
      compare("reply byte", e[i], u_host.got[i]);
    compare("busy", 1'b0, busy);
    u_host.got.delete();
  endtask
  // =========================================
  // Scenarios
  task automatic read_max();
    logic [7:0] e[$];
    logic [15:0] w;
    e = '{8'h01, 8'h03, 8'h18};
    for (int k = 0; k < 12; k++) begin
      w = 16'hA0FE + k[15:0];
      e.push_back(w[15:8]);
      e.push_back(w[7:0]);
    end
    send('{8'h01, 8'h03, 8'h00, 8'hFE, 8'h00, 8'h0C}, 1'b0);
    expect_reply(e);
    compare("read requests", 12, n_rd);
  endtask
  task automatic write_volatile();
    send('{8'h01, 8'h06, 8'h8F, 8'h05, 8'h13, 8'h88}, 1'b0);
    expect_reply('{8'h01, 8'h06, 8'h8F, 8'h05, 8'h13, 8'h88});
    compare("write port", {1'b1, 4'hF, 8'h05, 16'h1388}, wr_seen);
  endtask
  task automatic silent_frames();
    send('{8'h01, 8'h03, 8'h00, 8'h02, 8'h00, 8'h00}, 1'b0);
    send('{8'h01, 8'h03, 8'h00, 8'h02, 8'h00, 8'h0D}, 1'b0);
    compare("read requests", 12, n_rd);
    send('{8'h01, 8'h06, 8'h00, 8'h03, 8'h00, 8'h01}, 1'b1);
    compare("frame errors", 1, n_ferr);
    send('{8'h05, 8'h06, 8'h00, 8'h03, 8'h00, 8'h01}, 1'b0);
    compare("write port", {1'b1, 4'hF, 8'h05, 16'h1388}, wr_seen);
    send('{8'h00, 8'h06, 8'h00, 8'h03, 8'h00, 8'h02}, 1'b0);
    compare("write port", {1'b0, 4'h0, 8'h03, 16'h0002}, wr_seen);
    expect_reply('{});
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge i_clock);
    i_reset = 1'b0;
    repeat (100) @(negedge i_clock);
    read_max();
    write_volatile();
    silent_frames();
    give_verdict();
  end
endmodule
`default_nettype wire
